// [spwl_defs.svh]
// Constants for the signalling parameter word loader.
// Assumes a 250 MHz clock; included by every file.
`ifndef SPWL_DEFS_SVH
`define SPWL_DEFS_SVH

// Programming port address
`define SPWL_PROG_ADDR    8'hc8

// Control bits of a programming word
`define SPWL_FIRST_BIT    15
`define SPWL_SHORT_BIT    14
`define SPWL_BLK_HI       13
`define SPWL_BLK_LO       12

// Block numbers
`define SPWL_BLK_RSVD     3'h3
`define SPWL_BLK_GAIN     3'h4

// Word counts per block
`define SPWL_CNT_MODEM    5'h04
`define SPWL_CNT_SELCALL  5'h12
`define SPWL_CNT_SUBAUDIO 5'h05
`define SPWL_CNT_GAIN     5'h09

// First tone slot inside the selective-call block
`define SPWL_TONE_FIRST   5'h02

// Frame-sync reset values
`define SPWL_SYNC_RESET   16'hc4d7
`define SPWL_ALT_RESET    16'hb433

// Tone level ceiling and detect bandwidth codes
`define SPWL_LEVEL_MAX    11'h600
`define SPWL_BW_MIN       4'h8
`define SPWL_BW_MAX       4'hb
`define SPWL_BW_DEFAULT   4'h9

// Clock period, apply time and bound, in ns
`define SPWL_CLK_NS       4
`define SPWL_APPLY_NS     64
`define SPWL_APPLY_MAX_NS 250000
`define SPWL_APPLY_CYC    (`SPWL_APPLY_NS / `SPWL_CLK_NS)

`endif

// [spwl_pkg.sv]
// Types shared by the loader and its sync matcher.
// Assumes spwl_defs.svh is on the include path.
`include "spwl_defs.svh"

package spwl_pkg;

    // Ready-flag sequencer, Gray along off -> busy -> ready
    typedef enum logic [1:0] {
        ST_READY = 2'b00,
        ST_BUSY  = 2'b01,
        ST_OFF   = 2'b11
    } spwl_state_type;

    // Modem frame-sync patterns
    typedef struct packed {
        logic [15:0] primary;
        logic [15:0] alternate;
    } spwl_modem_type;

    // Selective-call settings
    typedef struct packed {
        logic [10:0] tx_level;
        logic        deemph_sel;
        logic [5:0]  threshold;
        logic [3:0]  bandwidth;
    } spwl_selcall_type;

    // Sub-audio settings
    typedef struct packed {
        logic [11:0] tx_level;
        logic        code_length_select;
        logic [5:0]  threshold;
        logic [3:0]  bandwidth;
        logic [23:0] code;
        logic [3:0]  dropout;
    } spwl_subaudio_type;

    // Gain, offset, ramp and limiter words
    typedef struct packed {
        logic [13:0] in_gain;
        logic [13:0] reserved;
        logic [13:0] out_gain1;
        logic [13:0] out_gain2;
        logic [13:0] offset1;
        logic [13:0] offset2;
        logic [13:0] ramp;
        logic [13:0] limiter;
        logic [13:0] test_word;
    } spwl_gain_type;

    // Frame-sync match pulses
    typedef struct packed {
        logic primary;
        logic alternate;
        logic inverted_frame_pattern;
    } spwl_sync_hit_type;

endpackage

// [spwl_frame_sync.sv]
// Frame-sync matcher for received modem bits.
// Assumes bits arrive on i_clk from same-clock demodulator logic.
`include "spwl_defs.svh"

module spwl_frame_sync
    import spwl_pkg::*;
(
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    // Received bit stream
    input  wire logic         i_bit_valid,
    input  wire logic         i_bit,
    // Patterns to look for
    input  wire logic [15:0]  i_primary,
    input  wire logic [15:0]  i_alternate,
    // One-cycle match pulses
    output spwl_sync_hit_type o_hit
);

    logic [15:0] shift;     // Oldest bit ends up in bit 15
    logic [4:0]  fill;      // Bits seen, saturates at 16
    logic [2:0]  match;     // Per-pattern compare result
    logic [15:0] pattern [3];

    ////////////////////////////////////////////////////////////////
    // inverse derived here
    assign pattern[2] = i_primary;
    assign pattern[1] = i_alternate;
    assign pattern[0] = ~i_primary;

    // One comparator per pattern; no hit before 16 bits are in
    generate
        for (genvar g = 0; g < 3; g++) begin : g_cmp
            assign match[g] = fill[4] && (shift == pattern[g]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // Shift in new bits at the low end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            shift <= 16'h0000;
            fill  <= 5'h00;
        end else if (i_bit_valid) begin
            shift <= {shift[14:0], i_bit};
            fill  <= fill[4] ? fill : fill + 5'h01;
        end
    end

    // Hits are sampled one cycle after the bit that completed them
    logic bit_seen;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bit_seen <= 1'b0;
            o_hit    <= '0;
        end else begin
            bit_seen <= i_bit_valid;
            o_hit    <= bit_seen ? spwl_sync_hit_type'(match) : '0;
        end
    end

endmodule

// [spwl_loader.sv]
// Word-serial parameter loader behind the programming port.
// Assumes writes arrive as one-cycle strobes on i_clk
// and control levels come from same-clock registers,
// so no synchroniser is needed.
`include "spwl_defs.svh"

// Behaviour
// - Top bits pick first word and block
// - Ready drops on write, returns when applied
// - Four modem bytes form two patterns
// - Earliest received bit meets high bit
// - Third pattern is inverse of primary
// - Patterns reset to fixed defaults
// - Tone level bits 11-1, at most 1536
// - De-emphasis needs voice, emphasis, bit 0
// - Second word holds 6-bit detect threshold
// - Low nibble selects detect bandwidth code
// - Sixteen tone words hold N and R
// - Sub-audio block takes five ordered words
// - Gain block takes nine 14-bit words
module spwl_loader
    import spwl_pkg::*;
(
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    // Programming port write strobe
    input  wire logic         i_wr_en,
    input  wire logic [7:0]   i_wr_addr,
    input  wire logic [15:0]  i_wr_data,
    // Device control levels
    input  wire logic         i_sp_enable,
    input  wire logic         i_keep_params,
    input  wire logic         i_voice_enable,
    input  wire logic         i_emph_enable,
    // Received modem bits
    input  wire logic         i_rx_bit_valid,
    input  wire logic         i_rx_bit,
    // Status
    output logic              o_prog_ready,
    // Parameter sets
    output spwl_modem_type    o_modem,
    output spwl_selcall_type  o_selcall,
    output logic [15:0][11:0] o_tones,
    output spwl_subaudio_type o_subaudio,
    output spwl_gain_type     o_gain,
    // Derived controls
    output logic              o_selcall_deemph,
    output spwl_sync_hit_type o_sync_hit
);

    ////////////////////////////////////////////////////////////////
    // Helper functions

    // Words a block may take; zero if reserved
    function automatic logic [4:0] blk_count(input logic [2:0] blk);
        logic [4:0] cnt;
        cnt = 5'h00;
        if (blk == 3'h0) begin
            cnt = `SPWL_CNT_MODEM;
        end else if (blk == 3'h1) begin
            cnt = `SPWL_CNT_SELCALL;
        end else if (blk == 3'h2) begin
            cnt = `SPWL_CNT_SUBAUDIO;
        end else if (blk == `SPWL_BLK_GAIN) begin
            cnt = `SPWL_CNT_GAIN;
        end
        return cnt;
    endfunction

    // Unlisted bandwidth codes become the default
    function automatic logic [3:0] bw_fix(input logic [3:0] code);
        logic [3:0] res;
        res = code;
        if (code < `SPWL_BW_MIN || code > `SPWL_BW_MAX) begin
            res = `SPWL_BW_DEFAULT;
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////
    // State

    spwl_state_type state;          // Ready-flag sequencer
    spwl_state_type next_state;
    logic           sp_enable_d;    // Previous enable, for edge
    logic [4:0]     busy_cnt;       // Cycles left before ready
    logic [2:0]     cur_blk;        // Block being filled
    logic           have_blk;       // First word seen
    logic [4:0]     word_idx;       // Last stored slot

    ////////////////////////////////////////////////////////////////
    // Word decode

    wire        wr_hit   = i_wr_en && (i_wr_addr == `SPWL_PROG_ADDR);
    wire        is_first = i_wr_data[`SPWL_FIRST_BIT];
    wire        is_short = i_wr_data[`SPWL_SHORT_BIT];
    wire [2:0]  blk      = is_short
                           ? {1'b0, i_wr_data[`SPWL_BLK_HI:`SPWL_BLK_LO]}
                           : `SPWL_BLK_GAIN;
    wire [13:0] data     = is_short ? {2'b00, i_wr_data[11:0]}
                                    : i_wr_data[13:0];

    // Writes while busy are dropped
    wire        accept   = wr_hit && (state == ST_READY);

    wire [4:0]  idx      = is_first ? 5'h00 : word_idx + 5'h01;

    wire        blk_ok   = (blk != `SPWL_BLK_RSVD)
                           && (is_first || (have_blk && blk == cur_blk));
    wire        idx_ok   = idx < blk_count(blk);
    wire        store    = accept && blk_ok && idx_ok;

    // Per-block store strobes
    wire        st_modem = store && (blk == 3'h0);
    wire        st_sel   = store && (blk == 3'h1);
    wire        st_sub   = store && (blk == 3'h2);
    wire        st_gain  = store && (blk == `SPWL_BLK_GAIN);

    // Enable edge and default load
    wire        sp_rise  = i_sp_enable && !sp_enable_d;
    wire        load_def = sp_rise && !i_keep_params;

    wire [10:0] lvl_raw  = data[11:1];
    wire [10:0] lvl      = (lvl_raw > `SPWL_LEVEL_MAX) ? `SPWL_LEVEL_MAX
                                                       : lvl_raw;

    // Tone slot from word index
    wire [4:0]  tone_off = idx - `SPWL_TONE_FIRST;
    wire        is_tone  = idx >= `SPWL_TONE_FIRST;

    ////////////////////////////////////////////////////////////////
    // Ready-flag sequencer

    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (i_sp_enable) begin
                    next_state = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (!i_sp_enable) begin
                    next_state = ST_OFF;
                end else if (busy_cnt == 5'h00) begin
                    next_state = ST_READY;
                end
            end
            ST_READY: begin
                if (!i_sp_enable) begin
                    next_state = ST_OFF;
                end else if (wr_hit) begin
                    next_state = ST_BUSY;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    // Busy time is far below the 250 us bound the host may wait
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state        <= ST_OFF;
            sp_enable_d  <= 1'b0;
            busy_cnt     <= 5'h00;
            o_prog_ready <= 1'b0;
        end else begin
            state        <= next_state;
            sp_enable_d  <= i_sp_enable;
            o_prog_ready <= (next_state == ST_READY);
            if (next_state == ST_BUSY && state != ST_BUSY) begin
                busy_cnt <= 5'(`SPWL_APPLY_CYC - 1);
            end else if (busy_cnt != 5'h00) begin
                busy_cnt <= busy_cnt - 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Block and word index

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cur_blk  <= 3'h0;
            have_blk <= 1'b0;
            word_idx <= 5'h00;
        end else if (load_def) begin
            have_blk <= 1'b0;
        end else if (store) begin
            cur_blk  <= blk;
            have_blk <= 1'b1;
            word_idx <= idx;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Modem patterns

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_modem.primary   <= `SPWL_SYNC_RESET;
            o_modem.alternate <= `SPWL_ALT_RESET;
        end else if (load_def) begin
            o_modem.primary   <= `SPWL_SYNC_RESET;
            o_modem.alternate <= `SPWL_ALT_RESET;
        end else if (st_modem) begin
            case (idx[1:0])
                2'h0:    o_modem.primary[7:0]    <= data[7:0];
                2'h1:    o_modem.primary[15:8]   <= data[7:0];
                2'h2:    o_modem.alternate[7:0]  <= data[7:0];
                default: o_modem.alternate[15:8] <= data[7:0];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Selective-call settings

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_selcall <= '0;
        end else if (load_def) begin
            o_selcall <= '0;
        end else if (st_sel && idx == 5'h00) begin
            o_selcall.tx_level   <= lvl;
            o_selcall.deemph_sel <= data[0];
        end else if (st_sel && idx == 5'h01) begin
            o_selcall.threshold  <= data[9:4];
            o_selcall.bandwidth  <= bw_fix(data[3:0]);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_tones <= '0;
        end else if (load_def) begin
            o_tones <= '0;
        end else if (st_sel && is_tone) begin
            o_tones[tone_off[3:0]] <= data[11:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_selcall_deemph <= 1'b0;
        end else begin
            o_selcall_deemph <= i_voice_enable && i_emph_enable
                                && o_selcall.deemph_sel;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sub-audio settings

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_subaudio <= '0;
        end else if (load_def) begin
            o_subaudio <= '0;
        end else if (st_sub) begin
            case (idx[2:0])
                3'h0: begin
                    o_subaudio.tx_level <= data[11:0];
                end
                3'h1: begin
                    o_subaudio.code_length_select <= data[11];
                    o_subaudio.threshold          <= data[9:4];
                    o_subaudio.bandwidth          <= data[3:0];
                end
                3'h2: begin
                    o_subaudio.code[11:0] <= data[11:0];
                end
                3'h3: begin
                    // Top code bit only counts for 24-bit codes
                    o_subaudio.code[23:12] <= {
                        data[11] & o_subaudio.code_length_select,
                        data[10:0]};
                end
                default: begin
                    o_subaudio.dropout <= data[11:8];
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Gain, offset, ramp and limiter

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_gain <= '0;
        end else if (load_def) begin
            o_gain <= '0;
        end else if (st_gain) begin
            case (idx[3:0])
                4'h0:    o_gain.in_gain   <= data;
                4'h1:    o_gain.reserved  <= data;
                4'h2:    o_gain.out_gain1 <= data;
                4'h3:    o_gain.out_gain2 <= data;
                4'h4:    o_gain.offset1   <= data;
                4'h5:    o_gain.offset2   <= data;
                4'h6:    o_gain.ramp      <= data;
                4'h7:    o_gain.limiter   <= data;
                default: o_gain.test_word <= data;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Frame-sync matcher

    spwl_frame_sync u_frame_sync (
        .i_clk       (i_clk),
        .i_rstn      (i_rstn),
        .i_bit_valid (i_rx_bit_valid),
        .i_bit       (i_rx_bit),
        .i_primary   (o_modem.primary),
        .i_alternate (o_modem.alternate),
        .o_hit       (o_sync_hit)
    );

endmodule

// [spwl_loader_checker.sv]
// Assertions on the loader's ports.
// Assumes one clock, async active-low reset.
`include "spwl_defs.svh"

module spwl_loader_checker
    import spwl_pkg::*;
(
    // Clock and reset
    input wire logic              i_clk,
    input wire logic              i_rstn,
    // Port and control levels
    input wire logic              i_wr_en,
    input wire logic [7:0]        i_wr_addr,
    input wire logic [15:0]       i_wr_data,
    input wire logic              i_sp_enable,
    input wire logic              i_voice_enable,
    input wire logic              i_emph_enable,
    // Observed outputs
    input wire logic              o_prog_ready,
    input wire spwl_modem_type    o_modem,
    input wire spwl_selcall_type  o_selcall,
    input wire spwl_subaudio_type o_subaudio,
    input wire spwl_gain_type     o_gain,
    input wire logic              o_selcall_deemph
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    ////////////////////////////////////////////////////////////////
    // Taken write
    wire acc = i_wr_en && i_wr_addr == `SPWL_PROG_ADDR && o_prog_ready && i_sp_enable;
    // Write while busy
    wire rude = i_wr_en && !o_prog_ready && i_sp_enable;

    // Sixteen busy cycles
    sequence s_busy;
        (!o_prog_ready) [*8] ##1 (!o_prog_ready) [*8];
    endsequence

    ////////////////////////////////////////////////////////////////
    a_ready_falls: assert property (acc |=> !o_prog_ready)
        else $error("ready high after write");
    a_ready_returns: assert property (acc |=> s_busy ##1 o_prog_ready)
        else $error("ready not back after busy");
    a_busy_ignored: assert property (rude && $past(i_sp_enable) && $past(i_rstn) |=>
        $stable(o_gain) && $stable(o_modem))
        else $error("busy write took effect");
    a_modem_byte: assert property (acc && i_wr_data[15:12] == 4'hc |=>
        o_modem.primary[7:0] == $past(i_wr_data[7:0]))
        else $error("modem byte 0 wrong");
    a_gain_first: assert property (acc && i_wr_data[15:14] == 2'b10 |=>
        o_gain.in_gain == $past(i_wr_data[13:0]))
        else $error("input gain wrong");
    a_sel_level: assert property (acc && i_wr_data[15:12] == 4'hd && i_wr_data[11:1] <= `SPWL_LEVEL_MAX |=>
        o_selcall.tx_level == $past(i_wr_data[11:1]) && o_selcall.deemph_sel == $past(i_wr_data[0]))
        else $error("selcall level wrong");
    a_sub_level: assert property (acc && i_wr_data[15:12] == 4'he |=>
        o_subaudio.tx_level == $past(i_wr_data[11:0]))
        else $error("sub level wrong");
    a_deemph_gate: assert property (o_selcall_deemph ==
        $past(i_voice_enable && i_emph_enable && o_selcall.deemph_sel))
        else $error("de-emphasis gate wrong");
endmodule

bind spwl_loader spwl_loader_checker u_checker (.i_clk(i_clk), .i_rstn(i_rstn), .i_wr_en(i_wr_en),
    .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_sp_enable(i_sp_enable),
    .i_voice_enable(i_voice_enable), .i_emph_enable(i_emph_enable), .o_prog_ready(o_prog_ready),
    .o_modem(o_modem), .o_selcall(o_selcall), .o_subaudio(o_subaudio), .o_gain(o_gain),
    .o_selcall_deemph(o_selcall_deemph));

// [spwl_host_model.sv]
// Host model writing words to the programming port.
// Assumes the bench holds i_req, i_word until o_done.
`include "spwl_defs.svh"

module spwl_host_model
    import spwl_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // Request from the bench
    input  wire logic        i_req,
    input  wire logic        i_no_wait,
    input  wire logic [15:0] i_word,
    // Device status
    input  wire logic        i_prog_ready,
    // Programming port
    output logic             o_wr_en,
    output logic [7:0]       o_wr_addr,
    output logic [15:0]      o_wr_data,
    output logic             o_done
);
    timeunit 1ns;
    timeprecision 1ps;

    // One strobe per request; idle lines invert
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_wr_en   <= 1'b0;
            o_done    <= 1'b0;
            o_wr_addr <= 8'h00;
            o_wr_data <= 16'h0000;
        end else if (i_req && !o_done && (i_prog_ready || i_no_wait)) begin
            o_wr_en   <= 1'b1;
            o_done    <= 1'b1;
            o_wr_addr <= `SPWL_PROG_ADDR;
            o_wr_data <= i_word;
        end else begin
            o_wr_en   <= 1'b0;
            o_done    <= 1'b0;
            o_wr_addr <= ~o_wr_addr;
            o_wr_data <= ~o_wr_data;
        end
    end
endmodule

// [spwl_loader_bench.sv]
// Self-checking bench for the word loader.
// Assumes package, checker, host model compiled first.
`include "spwl_defs.svh"

module spwl_loader_bench
    import spwl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Stimulus and observed signals
    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    logic              sp_en = 1'b0;
    logic              keep = 1'b0;
    logic              voice = 1'b0;
    logic              emph = 1'b0;
    logic              rx_valid = 1'b0;
    logic              rx_bit = 1'b0;
    logic              req = 1'b0;
    logic              no_wait = 1'b0;
    logic [15:0]       word = 16'h0000;
    logic              wr_en, done, ready, deemph;
    logic [7:0]        wr_addr;
    logic [15:0]       wr_data;
    spwl_modem_type    modem;
    spwl_selcall_type  selcall;
    logic [15:0][11:0] tones;
    spwl_subaudio_type sub;
    spwl_gain_type     gain;
    spwl_sync_hit_type hit;
    int                seed = 32'h58f3;
    int                n_errors = 0;
    int                num_checks = 0;

    always #2 clk = ~clk;

    spwl_loader u_spwl_loader (.i_clk(clk), .i_rstn(rstn), .i_wr_en(wr_en), .i_wr_addr(wr_addr),
        .i_wr_data(wr_data), .i_sp_enable(sp_en), .i_keep_params(keep), .i_voice_enable(voice),
        .i_emph_enable(emph), .i_rx_bit_valid(rx_valid), .i_rx_bit(rx_bit), .o_prog_ready(ready),
        .o_modem(modem), .o_selcall(selcall), .o_tones(tones), .o_subaudio(sub), .o_gain(gain),
        .o_selcall_deemph(deemph), .o_sync_hit(hit));
    spwl_host_model u_spwl_host_model (.i_clk(clk), .i_rstn(rstn), .i_req(req), .i_no_wait(no_wait),
        .i_word(word), .i_prog_ready(ready), .o_wr_en(wr_en), .o_wr_addr(wr_addr),
        .o_wr_data(wr_data), .o_done(done));

    ////////////////////////////////////////////////////////////////
    // Expected values
    function automatic logic exp_deemph(input logic v, input logic e, input logic s);
        return v & e & s;
    endfunction
    function automatic logic [23:0] exp_code(input logic [23:0] c, input logic len24);
        return {c[23] & len24, c[22:0]};
    endfunction

    // Compare one value and count it
    task automatic chk_val(input string name, input logic [127:0] exp, input logic [127:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One word via the host model, bounded wait
    task automatic put(input logic [15:0] w);
        int n = 0;
        req  <= 1'b1;
        word <= w;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 100);
        req <= 1'b0;
        if (n >= 100) chk_val("write", 1, 0);
        @(posedge clk);
    endtask

    // Bounded wait for ready
    task automatic idle();
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ready !== 1'b1 && n < 40);
        chk_val("ready", 1, ready);
    endtask

    // Send earliest bit first, gather hits
    task automatic send16(input logic [15:0] p, output spwl_sync_hit_type got);
        got = '0;
        for (int i = 15; i >= 0; i--) begin
            rx_valid <= 1'b1;
            rx_bit   <= p[i];
            @(posedge clk);
        end
        rx_valid <= 1'b0;
        repeat (4) begin
            @(posedge clk);
            got = got | hit;
        end
    endtask

    // Toggle enable, chosen keep bit
    task automatic cycle_enable(input logic k);
        keep  <= k;
        sp_en <= 1'b0;
        repeat (4) @(posedge clk);
        sp_en <= 1'b1;
        idle();
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Watchdog: run needs ~2k cycles, allow 50k
    initial begin
        #200000;
        n_errors++;
        final_report();
    end

    // Main sequence
    initial begin
        logic [7:0]        by [4];
        logic [11:0]       lvl;
        logic [5:0]        thr;
        logic [3:0]        bw;
        logic [23:0]       code;
        logic [11:0]       tn [16];
        logic [127:0]      eg;
        spwl_sync_hit_type h;
        spwl_gain_type     snap;
        repeat (20) @(posedge clk);
        chk_val("primary", `SPWL_SYNC_RESET, modem.primary);
        chk_val("alternate", `SPWL_ALT_RESET, modem.alternate);
        rstn  <= 1'b1;
        sp_en <= 1'b1;
        idle();
        // Modem bytes, earliest byte low
        for (int i = 0; i < 4; i++) by[i] = 8'($random(seed));
        put({8'hc0, by[0]});
        for (int i = 1; i < 4; i++) put({8'h40, by[i]});
        idle();
        chk_val("primary", {by[1], by[0]}, modem.primary);
        chk_val("alternate", {by[3], by[2]}, modem.alternate);
        send16({by[1], by[0]}, h);
        chk_val("hit primary", 1, h.primary);
        send16(~{by[1], by[0]}, h);
        chk_val("hit inverse", 1, h.inverted_frame_pattern);
        send16({by[3], by[2]}, h);
        chk_val("hit alt", 1, h.alternate);
        // Selcall: each bandwidth code, top level last
        for (int i = 0; i < 4; i++) begin
            lvl = (i == 3) ? 12'h600 : 12'($unsigned($random(seed)) % 1537);
            thr = 6'($random(seed));
            put({4'hd, lvl[10:0], i[0]});
            put({6'h14, thr, 4'h8 + 4'(i)});
            for (int t = 0; t < 16; t++) begin
                // host tone words, bit 11 clear
                tn[t] = {1'b0, 11'($random(seed))};
                put({4'h5, tn[t]});
            end
            idle();
            chk_val("level", lvl[10:0], selcall.tx_level);
            chk_val("threshold", thr, selcall.threshold);
            chk_val("bandwidth", 4'h8 + 4'(i), selcall.bandwidth);
            for (int t = 0; t < 16; t++) chk_val("tone", tn[t], tones[t]);
            for (int v = 0; v < 4; v++) begin
                voice <= v[0];
                emph  <= v[1];
                repeat (3) @(posedge clk);
                chk_val("deemph", exp_deemph(v[0], v[1], i[0]), deemph);
            end
        end
        // Sub-audio block with both code lengths
        for (int c = 0; c < 2; c++) begin
            lvl  = 12'($random(seed));
            thr  = 6'($random(seed));
            bw   = 4'($random(seed));
            code = 24'($random(seed));
            put({4'he, lvl});
            put({4'h6, c[0], 1'b0, thr, bw});
            put({4'h6, code[11:0]});
            put({4'h6, code[23:12]});
            put({4'h6, bw, 8'h00});
            idle();
            chk_val("sub level", lvl, sub.tx_level);
            chk_val("sub len", c[0], sub.code_length_select);
            chk_val("sub thr bw", {thr, bw}, {sub.threshold, sub.bandwidth});
            chk_val("sub code", exp_code(code, c[0]), sub.code);
            chk_val("sub drop", bw, sub.dropout);
        end
        // Gain block, eight words
        eg = '0;
        for (int k = 0; k < 8; k++) begin
            lvl = (k == 1) ? 12'h000 : 12'($random(seed));
            put({(k == 0) ? 2'b10 : 2'b00, lvl[1:0], lvl});
            eg = (eg << 14) | {lvl[1:0], lvl};
        end
        idle();
        chk_val("gain", eg << 14, gain);
        // block 3 word, then a busy write, both dropped
        snap = gain;
        put(16'hf123);
        no_wait <= 1'b1;
        put(16'h8abc);
        no_wait <= 1'b0;
        idle();
        chk_val("gain kept", snap, gain);
        cycle_enable(1'b1);
        chk_val("kept pattern", {by[1], by[0]}, modem.primary);
        cycle_enable(1'b0);
        chk_val("reload", {`SPWL_SYNC_RESET, `SPWL_ALT_RESET}, modem);
        final_report();
    end
endmodule
